// *** src/gfbl_fifo.sv ***
// Command FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module gfbl_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // State
    output logic empty,
    output logic full
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("gfbl_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] cnt_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    wire logic push;
    wire logic load;
    wire logic pop;

    // Room counts storage words only; the output stage holds one more
    assign in_ready = (cnt_q < (PW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = out_valid_q && out_ready;
    // Output register refills while being drained, no bubble
    assign load = (cnt_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign empty = (cnt_q == '0) && !out_valid_q;
    assign full = !in_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PW'(push);
            rd_ptr_q <= rd_ptr_q + PW'(load);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(load);
            if (load) begin
                out_data_q <= mem_q[rd_ptr_q];
            end
            if (load) begin
                out_valid_q <= 1'b1;
            end else if (pop) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule : gfbl_fifo
`default_nettype wire

// *** src/gfbl_link.sv ***
// Software-driven parallel link port towards FPGA logic
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gfbl_link
    import gfbl_pkg::*;
#(
    parameter int RESP_CYC = RESP_WAIT_CYC,
    parameter int HOLD_CYC = PIN_HOLD_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Shared data path to the FPGA
    input wire logic [DATA_W-1:0] pio_data_i,
    output logic [DATA_W-1:0] pio_data_o,
    output logic pio_data_oe,
    // Control lines to the FPGA
    output logic pio_start,
    output logic pio_wr,
    output logic pio_rd
);
    // Both waits load a 16-bit down-counter
    if (RESP_CYC < 1 || HOLD_CYC < 1 || RESP_CYC > 65536
            || HOLD_CYC > 65536) begin : g_chk
        $error("gfbl_link: RESP_CYC and HOLD_CYC must be 1 to 65536");
    end

    // Write channel holding registers
    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Pin side
    logic [DATA_W-1:0] dout_q;
    logic oe_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [DATA_W-1:0] sample_q;
    logic done_q;
    gfbl_state_t state_q;
    logic [15:0] cnt_q;
    // FIFO wiring
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [CMD_W-1:0] fifo_out_data;
    logic fifo_empty;
    logic fifo_full;

    // Write decode
    wire logic wr_is_data = (aw_addr_q == REG_DATA);
    wire logic wr_is_ctrl = (aw_addr_q == REG_CTRL);
    wire logic wr_is_smpl = (aw_addr_q == REG_SAMPLE);
    wire logic wr_queued = wr_is_data || wr_is_ctrl || wr_is_smpl;
    wire logic wr_ok = wr_queued && (w_strb_q == STRB_FULL);
    wire logic wr_both = aw_held_q && w_held_q && !bvalid_q;
    // Full FIFO stalls the write response, so software waits
    wire logic wr_fire = wr_both && (!wr_ok || fifo_in_ready);
    wire logic push = wr_fire && wr_ok;
    wire gfbl_op_t push_op = wr_is_data ? OP_DRIVE
        : (wr_is_ctrl ? OP_CTRL : OP_SAMPLE);
    wire logic [CMD_W-1:0] push_cmd = {push_op, w_data_q};

    // Read decode
    wire logic rd_take = s_axi_arvalid && !rvalid_q;
    wire logic [31:0] status_word = {27'h000_0000, oe_q, fifo_full,
        fifo_empty, (state_q != ST_RUN) || !fifo_empty, done_q};
    wire logic rd_hit = (s_axi_araddr == REG_DATA)
        || (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_SAMPLE)
        || (s_axi_araddr == REG_RDATA) || (s_axi_araddr == REG_STATUS);
    wire logic [31:0] rd_word =
        (s_axi_araddr == REG_DATA) ? dout_q
        : (s_axi_araddr == REG_CTRL) ? {29'h0000_0000, ctrl_q}
        : (s_axi_araddr == REG_RDATA) ? sample_q
        : (s_axi_araddr == REG_STATUS) ? status_word : WORD_ZERO;
    wire logic rd_clear = rd_take && (s_axi_araddr == REG_RDATA);

    // Executor decode
    wire gfbl_op_t pop_op = gfbl_op_t'(fifo_out_data[CMD_W-1:DATA_W]);
    wire logic [DATA_W-1:0] pop_word = fifo_out_data[DATA_W-1:0];
    wire logic pop = fifo_out_valid && (state_q == ST_RUN);
    wire logic cnt_zero = (cnt_q == 16'h0000);
    wire logic sample_now = (state_q == ST_WAIT) && cnt_zero;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign pio_data_o = dout_q;
    assign pio_data_oe = oe_q;
    assign pio_start = ctrl_q[CTRL_START_BIT];
    assign pio_wr = ctrl_q[CTRL_WR_BIT];
    assign pio_rd = ctrl_q[CTRL_RD_BIT];

    gfbl_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_cmd),
        .out_valid(fifo_out_valid),
        .out_ready(state_q == ST_RUN),
        .out_data(fifo_out_data),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // Write address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= WORD_ZERO;
            w_strb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Pin sequencer: each queued write changes the pins once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            cnt_q <= '0;
            dout_q <= WORD_ZERO;
            oe_q <= 1'b1;
            ctrl_q <= CTRL_CLEAR;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (pop && pop_op == OP_DRIVE) begin
                        dout_q <= pop_word;
                        oe_q <= 1'b1;
                    end
                    if (pop && pop_op == OP_CTRL) begin
                        ctrl_q <= pop_word[CTRL_W-1:0];
                    end
                    if (pop && pop_op == OP_SAMPLE) begin
                        oe_q <= 1'b0;
                        state_q <= ST_WAIT;
                        cnt_q <= 16'(RESP_CYC - 1);
                    end else if (pop) begin
                        // Minimum pin hold helps the far-end oversampler
                        state_q <= ST_HOLD;
                        cnt_q <= 16'(HOLD_CYC - 1);
                    end
                end
                ST_HOLD: begin
                    if (cnt_zero) begin
                        state_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_WAIT: begin
                    if (cnt_zero) begin
                        state_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Sampled word and sticky done; a new sample wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_q <= WORD_ZERO;
            done_q <= 1'b0;
        end else if (sample_now) begin
            sample_q <= pio_data_i;
            done_q <= 1'b1;
        end else if (rd_clear) begin
            done_q <= 1'b0;
        end
    end

    // Checks
    oe_off_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
        pop && pop_op == OP_SAMPLE |=> !pio_data_oe && state_q == ST_WAIT)
        else $error("data lines not released for read");
    wait_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_q == ST_WAIT) |-> cnt_q == 16'(RESP_CYC - 1))
        else $error("response wait length wrong");
    input_held_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_WAIT |-> !pio_data_oe)
        else $error("data lines driven during response wait");
    sample_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_now |=> done_q && sample_q == $past(pio_data_i))
        else $error("sampled word not captured");
    ctrl_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(ctrl_q) |-> $past(pop) && $past(pop_op) == OP_CTRL)
        else $error("control lines moved without a command");
    data_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(dout_q) |-> $past(pop) && $past(pop_op) == OP_DRIVE)
        else $error("data lines moved without a command");
    start_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pio_start) |-> pio_start ##1 pio_start)
        else $error("start pulse too short for oversampling");
    full_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_both && wr_ok && !fifo_in_ready |=> !s_axi_bvalid)
        else $error("write answered while queue full");
    drive_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        pop && pop_op == OP_DRIVE |=> pio_data_oe
        && pio_data_o == $past(pop_word))
        else $error("address or data not driven");
    ctrl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        pop && pop_op == OP_CTRL |=>
        pio_start == $past(pop_word[CTRL_START_BIT])
        && pio_wr == $past(pop_word[CTRL_WR_BIT])
        && pio_rd == $past(pop_word[CTRL_RD_BIT]))
        else $error("control lines not set as queued");
    bad_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fire && !wr_ok |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("refused write not answered as error");
    bad_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_take && !rd_hit |=> s_axi_rvalid && s_axi_rdata == WORD_ZERO
        && s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not answered as error");
    done_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_q) |-> $past(state_q) == ST_WAIT && !pio_data_oe)
        else $error("done raised outside a read wait");
endmodule : gfbl_link
`default_nettype wire

// *** src/gfbl_pkg.sv ***
// Shared constants and types for the parallel FPGA link port
package gfbl_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESP_WAIT_NS = 250;
    localparam int RESP_WAIT_CYC = (RESP_WAIT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PIN_HOLD_NS = 20;
    localparam int PIN_HOLD_CYC = (PIN_HOLD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    // Link widths
    localparam int DATA_W = 32;
    localparam int CTRL_W = 3;
    localparam int FIFO_DEPTH = 32;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_DATA = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_SAMPLE = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_RD_BIT = 2;

    // Status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_FULL_BIT = 3;
    localparam int STAT_OE_BIT = 4;

    // Bus answers and reset values
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_FULL = 4'hf;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [2:0] CTRL_CLEAR = 3'h0;

    // Queued pin operations
    typedef enum logic [1:0] {
        OP_DRIVE,
        OP_CTRL,
        OP_SAMPLE
    } gfbl_op_t;

    localparam int OP_W = 2;
    localparam int CMD_W = OP_W + DATA_W;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_WAIT
    } gfbl_state_t;
endpackage : gfbl_pkg

// *** verif/gfbl_fpga_model.sv ***
// Behavioural FPGA-side decoder facing the parallel link
`timescale 1ns/1ps
`default_nettype none
module gfbl_fpga_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link as seen on the wire
    input wire logic [31:0] bus,
    input wire logic start,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] delay,
    // Read answer
    output logic [31:0] drv_data,
    output logic drv_oe,
    // Decoded traffic
    output logic [31:0] got_addr,
    output logic [31:0] got_data,
    output logic [7:0] wr_count
);
    logic start_q;
    logic dir_wr_q;
    logic pend_q;
    logic [15:0] cnt_q;
    wire logic rise = start && !start_q;
    // Sampled every clock, far faster than software pin changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            dir_wr_q <= 1'b0;
            pend_q <= 1'b0;
            cnt_q <= 16'h0000;
            drv_oe <= 1'b0;
            drv_data <= 32'h0000_0000;
            got_addr <= 32'h0000_0000;
            got_data <= 32'h0000_0000;
            wr_count <= 8'h00;
        end else begin
            start_q <= start;
            if (pend_q) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            if (pend_q && cnt_q == delay) begin
                drv_oe <= 1'b1;
                drv_data <= got_addr ^ 32'h5a5a_0ff0;
                pend_q <= 1'b0;
            end
            if (rise && (wr || rd)) begin
                got_addr <= bus;
                dir_wr_q <= wr;
                pend_q <= rd;
                cnt_q <= 16'h0000;
                // Lines freed on the clock that sees start rise for a new address phase
                drv_oe <= 1'b0;
            end else if (rise && dir_wr_q) begin
                got_data <= bus;
                wr_count <= wr_count + 8'h01;
            end
        end
    end
endmodule : gfbl_fpga_model
`default_nettype wire

// *** verif/tb_gfbl_fpga_bus_link.sv ***
// Self-checking bench for the parallel FPGA link port
`timescale 1ns/1ps
`default_nettype none
module tb_gfbl_fpga_bus_link;
    import gfbl_pkg::*;
    typedef struct packed {
        logic rd;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
    } gfbl_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, pio_o, m_data, m_addr, m_wdata, d;
    logic [31:0] pio_wire, last_q = 32'h0000_0000;
    logic pio_oe, p_start, p_wr, p_rd, m_oe;
    logic [7:0] m_count;
    logic [15:0] m_delay = 16'h0002;
    logic [1:0] r;
    int num_errors = 0, checks_done = 0, n_wr = 0;
    gfbl_row_t rows [4];
    always #5 clk = ~clk;
    // Released wire has no pull: it shows the inverse of its last level
    assign pio_wire = pio_oe ? pio_o : (m_oe ? m_data : ~last_q);
    always @(posedge clk) if (pio_oe || m_oe) last_q <= pio_wire;
    gfbl_link #(.RESP_CYC(25), .HOLD_CYC(2), .DEPTH(32)) gfbl_link_i (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .pio_data_i(pio_wire), .pio_data_o(pio_o), .pio_data_oe(pio_oe),
        .pio_start(p_start), .pio_wr(p_wr), .pio_rd(p_rd));
    gfbl_fpga_model gfbl_fpga_model_i (
        .clk(clk), .rst_n(rst_n), .bus(pio_wire), .start(p_start),
        .wr(p_wr), .rd(p_rd), .delay(m_delay), .drv_data(m_data),
        .drv_oe(m_oe), .got_addr(m_addr), .got_data(m_wdata),
        .wr_count(m_count));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_up();
        num_errors++;
        report_and_stop();
    endtask : give_up
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [3:0] s, output logic [1:0] resp);
        int n;
        @(posedge clk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v;
        wstrb <= s; bready <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 400) give_up();
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        int n;
        @(posedge clk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 400) give_up();
        v = rdata; resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        axi_wr(a, v, STRB_FULL, rs);
        check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    endtask : wr
    task automatic poll(input int bit_no, input logic want, input int lim);
        logic [31:0] st;
        logic [1:0] rs;
        int n;
        for (n = 0; n < lim; n++) begin
            axi_rd(REG_STATUS, st, rs);
            if (st[bit_no] === want) break;
        end
        if (n == lim) give_up();
    endtask : poll
    task automatic link_rd(input logic [31:0] a, output logic [31:0] v);
        logic [1:0] rs;
        logic [31:0] st;
        wr(REG_DATA, a); wr(REG_CTRL, 32'h0000_0005);
        wr(REG_CTRL, 32'h0000_0000); wr(REG_SAMPLE, 32'h0000_0000);
        axi_rd(REG_STATUS, st, rs);
        check("early_done", {31'h0, st[STAT_DONE_BIT]}, 32'h0);
        poll(STAT_DONE_BIT, 1'b1, 100);
        axi_rd(REG_RDATA, v, rs);
        axi_rd(REG_STATUS, st, rs);
        check("done_clr", {31'h0, st[STAT_DONE_BIT]}, 32'h0);
        check("oe_low", {31'h0, st[STAT_OE_BIT]}, 32'h0);
    endtask : link_rd
    initial begin
        rows[0] = '{1'b0, 32'h0000_0040, 32'h1234_5678, 32'h1234_5678};
        rows[1] = '{1'b0, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000};
        rows[2] = '{1'b1, 32'h0000_0100, 32'h0, 32'h5a5a_0ef0};
        rows[3] = '{1'b1, 32'h0000_0000, 32'h0, 32'h5a5a_0ff0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(REG_STATUS, d, r);
        check("status_rst", d, 32'h0000_0014);
        axi_rd(REG_CTRL, d, r);
        check("ctrl_rst", d, 32'h0000_0000);
        foreach (rows[i]) begin
            if (rows[i].rd) begin
                link_rd(rows[i].addr, d);
                check("rd_word", d, rows[i].exp);
            end else begin
                wr(REG_DATA, rows[i].addr);
                wr(REG_CTRL, 32'h0000_0003);
                wr(REG_CTRL, 32'h0000_0000);
                wr(REG_DATA, rows[i].data);
                wr(REG_CTRL, 32'h0000_0001);
                wr(REG_CTRL, 32'h0000_0000);
                poll(STAT_BUSY_BIT, 1'b0, 100);
                n_wr++;
                check("wr_addr", m_addr, rows[i].addr);
                check("wr_data", m_wdata, rows[i].exp);
                check("wr_count", {24'h0, m_count}, n_wr);
            end
        end
        // Late answer from the far side must not be what gets sampled
        m_delay <= 16'd200;
        link_rd(32'h0000_0100, d);
        // Nobody drives at the sample: the wire shows the address inverted
        check("late", d, 32'hffff_feff);
        axi_rd(8'h14, d, r);
        check("unmap_d", d, 32'h0000_0000);
        check("unmap_r", {30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(REG_STATUS, 32'h0000_00ff, STRB_FULL, r);
        check("ro_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(REG_DATA, 32'hdead_beef, 4'h3, r);
        check("strb_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        // Long sample waits let the queue back up until it is full and stalls the writes
        for (int k = 0; k < 40; k++) wr(REG_SAMPLE, 32'h0000_0000);
        axi_rd(REG_STATUS, d, r);
        check("full", {31'h0, d[STAT_FULL_BIT]}, 32'h1);
        poll(STAT_BUSY_BIT, 1'b0, 1000);
        axi_rd(REG_STATUS, d, r);
        check("empty", {31'h0, d[STAT_EMPTY_BIT]}, 32'h1);
        // Second reset with start raised: pins and status go back to idle
        wr(REG_DATA, 32'h0000_0200);
        wr(REG_CTRL, 32'h0000_0003);
        axi_rd(REG_CTRL, d, r);
        check("ctrl_rd", d, 32'h0000_0003);
        axi_rd(REG_DATA, d, r);
        check("data_rd", d, 32'h0000_0200);
        axi_rd(REG_SAMPLE, d, r);
        check("smpl_rd", d, 32'h0000_0000);
        check("start_up", {31'h0, p_start}, 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("rst_pins", {28'h0, pio_oe, p_start, p_wr, p_rd},
              32'h0000_0008);
        rst_n <= 1'b1;
        axi_rd(REG_STATUS, d, r);
        check("status_rst2", d, 32'h0000_0014);
        report_and_stop();
    end
endmodule : tb_gfbl_fpga_bus_link
`default_nettype wire
